//--- hdl/atd_pkg.sv
// package: register map, field layout and timing constants of the auto transfer unit
// Operation
// - start on selected trigger or software flag
// - request bus, wait grant before cycles
// - byte transfer is load then store
// - words and streams repeat byte transfers
// - accesses take two or three cycles
// - activation to first load within eight
// - pointer zero is 18 bits, three bytes
// - increment disable bit freezes pointer zero
// - I/O pointer upper bits forced to 03F
// - pointer one increments in some modes
// - counter zero refuses activation
// - standard mode: one operation, decrement, irq at zero
// - no start after counter reached zero
// - burst moves count bytes, then irq
// - counter holds up to 255
// - burst stops on ext0 flag if enabled
// - emergency stop keeps counter and pointers
// - sixteen modes: 0-D standard, E-F burst
// - word I/O: even address, then odd
// - modes 0 and 1 keep both pointers
package atd_pkg;
   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [7:0] ATD_OFF_CTRL0 = 8'h00;
   localparam logic [7:0] ATD_OFF_CTRL1 = 8'h04;
   localparam logic [7:0] ATD_OFF_COUNT = 8'h08;
   localparam logic [7:0] ATD_OFF_P0L = 8'h0C;
   localparam logic [7:0] ATD_OFF_P0M = 8'h10;
   localparam logic [7:0] ATD_OFF_P0H = 8'h14;
   localparam logic [7:0] ATD_OFF_P1L = 8'h18;
   localparam logic [7:0] ATD_OFF_P1M = 8'h1C;
   localparam logic [7:0] ATD_OFF_P1H = 8'h20;
   localparam logic [7:0] ATD_OFF_STAT = 8'h24;
   // ****************************************
   // fields
   // ****************************************
   localparam int ATD_C0_MODE_LSB = 0;
   localparam int ATD_C0_INCDIS_BIT = 4;
   localparam int ATD_C1_TRIG_LSB = 0;
   localparam int ATD_C1_BSTOP_BIT = 4;
   localparam int ATD_C1_SWACT_BIT = 7;
   localparam logic [3:0] ATD_MODE_BURST_E = 4'hE;
   localparam logic [9:0] ATD_IO_UPPER = 10'h03F;
   localparam logic [1:0] ATD_RESP_OKAY = 2'b00;
   localparam logic [1:0] ATD_RESP_SLVERR = 2'b10;
   // ****************************************
   // timing
   // ****************************************
   localparam int ATD_CLK_MHZ = 125;
   localparam int ATD_ACC_MEM_CYC = 2;
   localparam int ATD_ACC_IO_CYC = 3;
   localparam logic [1:0] ATD_ACC_MEM_LAST = 2'(ATD_ACC_MEM_CYC - 1);
   localparam logic [1:0] ATD_ACC_IO_LAST = 2'(ATD_ACC_IO_CYC - 1);
endpackage

//--- hdl/atd_axil.sv
// file: AXI4-Lite slave front end for the auto transfer unit
`timescale 1ns/1ps
`default_nettype none
module atd_axil
   import atd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [7:0] s_awaddr,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [7:0] s_araddr,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_hit,
   input wire logic wr_hit
);
   typedef struct packed {
      logic aw_full;
      logic [7:0] aw;
      logic w_full;
      logic [7:0] wd;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } atd_bus_t;
   atd_bus_t q, d;

   // write fires once both halves are held and no response is pending
   logic fire;
   assign fire = q.aw_full && q.w_full && !q.bvalid;
   assign wr_en = fire && q.wlane && wr_hit;
   assign wr_addr = q.aw;
   assign wr_data = q.wd;
   assign rd_addr = s_araddr;

   always_comb begin
      d = q;
      if (s_awvalid && !q.aw_full) begin
         d.aw_full = 1'b1;
         d.aw = s_awaddr;
      end
      if (s_wvalid && !q.w_full) begin
         d.w_full = 1'b1;
         d.wd = s_wdata[7:0];
         d.wlane = s_wstrb[0];
      end
      if (fire) begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = wr_hit ? ATD_RESP_OKAY : ATD_RESP_SLVERR;
      end else if (q.bvalid && s_bready) begin
         d.bvalid = 1'b0;
      end
      if (s_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rdata = rd_data;
         d.rresp = rd_hit ? ATD_RESP_OKAY : ATD_RESP_SLVERR;
      end else if (q.rvalid && s_rready) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign s_awready = !q.aw_full;
   assign s_wready = !q.w_full;
   assign s_bvalid = q.bvalid;
   assign s_bresp = q.bresp;
   assign s_arready = !q.rvalid;
   assign s_rvalid = q.rvalid;
   assign s_rdata = {24'h00_0000, q.rdata};
   assign s_rresp = q.rresp;
endmodule // atd_axil
`default_nettype wire

//--- hdl/atd_top.sv
// file: auto transfer unit, single channel byte DMA with register slave
`timescale 1ns/1ps
`default_nettype none
module atd_top
   import atd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [7:0] s_awaddr,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [7:0] s_araddr,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   input wire logic [15:0] trigger_in,
   input wire logic ext0_request_flag,
   output logic bus_request,
   input wire logic bus_grant,
   output logic mem_rd,
   output logic mem_wr,
   output logic [17:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   output logic transfer_done_irq
);
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [2:0] {
      ATD_IDLE = 3'b000,
      ATD_REQ = 3'b001,
      ATD_LOAD = 3'b011,
      ATD_STORE = 3'b010,
      ATD_NEXT = 3'b110
   } atd_state_t;

   typedef struct packed {
      atd_state_t st;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] count;
      logic [17:0] ptr0;
      logic [17:0] ptr1;
      logic [7:0] data;
      logic [1:0] wait_cnt;
      logic second;
      logic pending;
      logic done;
      logic [15:0] trig_prev;
      logic bus_request;
      logic mem_rd;
      logic mem_wr;
      logic [17:0] mem_addr;
      logic [7:0] mem_wdata;
      logic irq;
   } atd_regs_t;
   atd_regs_t q, d;

   logic wr_en, rd_hit, wr_hit;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;

   atd_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_awaddr(s_awaddr),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_bresp(s_bresp),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_araddr(s_araddr),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_hit(rd_hit),
      .wr_hit(wr_hit)
   );

   // ****************************************
   // mode decode
   // ****************************************
   logic [3:0] mode;
   logic incdis, bstop, burst, io_mode, p1_inc, dir_p1_src, two_bytes, p0_inc_ok;
   assign mode = q.ctrl0[ATD_C0_MODE_LSB +: 4];
   assign incdis = q.ctrl0[ATD_C0_INCDIS_BIT];
   assign bstop = q.ctrl1[ATD_C1_BSTOP_BIT];
   assign burst = (mode >= ATD_MODE_BURST_E);
   assign io_mode = (mode <= 4'h9);
   assign p1_inc = (mode >= 4'hC);
   assign two_bytes = (mode >= 4'h4 && mode <= 4'h9) || mode == 4'hC || mode == 4'hD;
   // direction per byte: odd modes read pointer one; 6-9 read pointer one on first byte, pointer zero on second
   always_comb begin
      dir_p1_src = mode[0];
      if (mode >= 4'h6 && mode <= 4'h9) begin
         dir_p1_src = !q.second;
      end
   end
   // pointer zero step per byte; 0,1,A,B fixed, 7 and 9 hold on second
   always_comb begin
      unique case (mode)
         4'h0, 4'h1, 4'hA, 4'hB: p0_inc_ok = 1'b0;
         4'h7, 4'h9: p0_inc_ok = !q.second;
         default: p0_inc_ok = 1'b1;
      endcase
   end

   // I/O window replaces upper ten bits; odd partner for word modes
   logic [17:0] p1_eff;
   always_comb begin
      p1_eff = q.ptr1;
      if (io_mode) begin
         p1_eff = {ATD_IO_UPPER, q.ptr1[7:0]};
         if ((mode == 4'h4 || mode == 4'h5 || mode == 4'h8 || mode == 4'h9) && q.second) begin
            p1_eff[0] = 1'b1;
         end
      end
   end

   logic [17:0] src, dst;
   assign src = dir_p1_src ? p1_eff : q.ptr0;
   assign dst = dir_p1_src ? q.ptr0 : p1_eff;

   // I/O accesses cost one cycle more than memory
   logic [1:0] acc_last;
   assign acc_last = (q.mem_addr[17:8] == ATD_IO_UPPER) ? ATD_ACC_IO_LAST : ATD_ACC_MEM_LAST;

   // ****************************************
   // triggers
   // ****************************************
   logic trig_edge, sw_act;
   logic [3:0] tsel;
   assign tsel = q.ctrl1[ATD_C1_TRIG_LSB +: 4];
   assign trig_edge = trigger_in[tsel] && !q.trig_prev[tsel];
   assign sw_act = wr_en && wr_addr == ATD_OFF_CTRL1 && wr_data[ATD_C1_SWACT_BIT];

   // ****************************************
   // register read mux
   // ****************************************
   always_comb begin
      rd_hit = 1'b1;
      unique case (rd_addr)
         ATD_OFF_CTRL0: rd_data = q.ctrl0;
         ATD_OFF_CTRL1: rd_data = {1'b0, q.ctrl1[6:0]};
         ATD_OFF_COUNT: rd_data = q.count;
         ATD_OFF_P0L: rd_data = q.ptr0[7:0];
         ATD_OFF_P0M: rd_data = q.ptr0[15:8];
         ATD_OFF_P0H: rd_data = {6'h00, q.ptr0[17:16]};
         ATD_OFF_P1L: rd_data = q.ptr1[7:0];
         ATD_OFF_P1M: rd_data = q.ptr1[15:8];
         ATD_OFF_P1H: rd_data = {6'h00, q.ptr1[17:16]};
         ATD_OFF_STAT: rd_data = {5'h00, q.done, q.pending, q.st != ATD_IDLE};
         default: begin
            rd_data = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end
   assign wr_hit = wr_addr <= ATD_OFF_STAT && wr_addr[1:0] == 2'b00;

   // ****************************************
   // engine
   // ****************************************
   always_comb begin
      d = q;
      d.trig_prev = trigger_in;
      d.irq = 1'b0;
      d.mem_rd = 1'b0;
      d.mem_wr = 1'b0;
      if (wr_en && q.st == ATD_IDLE) begin
         unique case (wr_addr)
            ATD_OFF_CTRL0: d.ctrl0 = wr_data;
            ATD_OFF_CTRL1: d.ctrl1 = {1'b0, wr_data[6:0]};
            ATD_OFF_COUNT: begin
               d.count = wr_data;
               d.done = 1'b0;
            end
            ATD_OFF_P0L: d.ptr0[7:0] = wr_data;
            ATD_OFF_P0M: d.ptr0[15:8] = wr_data;
            ATD_OFF_P0H: d.ptr0[17:16] = wr_data[1:0];
            ATD_OFF_P1L: d.ptr1[7:0] = wr_data;
            ATD_OFF_P1M: d.ptr1[15:8] = wr_data;
            ATD_OFF_P1H: d.ptr1[17:16] = wr_data[1:0];
            default: ;
         endcase
      end
      unique case (q.st)
         ATD_IDLE: begin
            if (q.pending && q.count != 8'h00) begin
               d.pending = 1'b0;
               d.bus_request = 1'b1;
               d.second = 1'b0;
               d.st = ATD_REQ;
            end else begin
               d.pending = 1'b0;
            end
         end
         ATD_REQ: begin
            // core answers within four cycles, first load follows at once
            if (bus_grant) begin
               d.mem_rd = 1'b1;
               d.mem_addr = src;
               d.wait_cnt = 2'd0;
               d.st = ATD_LOAD;
            end
         end
         ATD_LOAD: begin
            if (q.wait_cnt == acc_last) begin
               d.data = mem_rdata;
               d.mem_wr = 1'b1;
               d.mem_addr = dst;
               d.mem_wdata = mem_rdata;
               d.wait_cnt = 2'd0;
               d.st = ATD_STORE;
            end else begin
               d.mem_rd = 1'b1;
               d.wait_cnt = q.wait_cnt + 2'd1;
            end
         end
         ATD_STORE: begin
            if (q.wait_cnt == acc_last) begin
               if (p0_inc_ok && !incdis) begin
                  d.ptr0 = q.ptr0 + 18'd1;
               end
               if (p1_inc) begin
                  d.ptr1 = q.ptr1 + 18'd1;
               end
               d.st = ATD_NEXT;
            end else begin
               d.mem_wr = 1'b1;
               d.wait_cnt = q.wait_cnt + 2'd1;
            end
         end
         ATD_NEXT: begin
            if (burst) begin
               d.count = q.count - 8'd1;
               if (q.count == 8'd1) begin
                  d.irq = 1'b1;
                  d.done = 1'b1;
                  d.bus_request = 1'b0;
                  d.st = ATD_IDLE;
               end else if (bstop && ext0_request_flag) begin
                  // pointers and count stand as they are for resume
                  d.bus_request = 1'b0;
                  d.st = ATD_IDLE;
               end else begin
                  d.st = ATD_REQ;
               end
            end else if (two_bytes && !q.second) begin
               d.second = 1'b1;
               d.st = ATD_REQ;
            end else begin
               d.count = q.count - 8'd1;
               d.bus_request = 1'b0;
               d.st = ATD_IDLE;
               if (q.count == 8'd1) begin
                  d.irq = 1'b1;
                  d.done = 1'b1;
               end
            end
         end
         default: d.st = ATD_IDLE;
      endcase
      // a request is caught even mid-operation and served afterward
      // set last, so a fresh request wins over the clear taken at start
      if ((trig_edge || sw_act) && q.count != 8'h00 && !q.done) begin
         d.pending = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus_request = q.bus_request;
   assign mem_rd = q.mem_rd;
   assign mem_wr = q.mem_wr;
   assign mem_addr = q.mem_addr;
   assign mem_wdata = q.mem_wdata;
   assign transfer_done_irq = q.irq;
endmodule // atd_top
`default_nettype wire

//--- test/atd_chk_assertions.sv
// checker: bus ownership and access timing of the auto transfer unit
`timescale 1ns/1ps
`default_nettype none
module atd_chk
   import atd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_request,
   input wire logic bus_grant,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [17:0] mem_addr,
   input wire logic transfer_done_irq
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic io;
   // io status is read at the first access cycle, where the address is already set
   assign io = mem_addr[17:8] == ATD_IO_UPPER;
   a_access_granted: assert property ((mem_rd || mem_wr) |-> bus_grant && bus_request)
      else $error("access without grant");
   a_rd_wr_excl: assert property (!(mem_rd && mem_wr))
      else $error("load and store overlap");
   a_mem_load_len: assert property ($rose(mem_rd) && !io |-> mem_rd [*2] ##1 !mem_rd)
      else $error("memory load length");
   a_io_load_len: assert property ($rose(mem_rd) && io |-> mem_rd [*3] ##1 !mem_rd)
      else $error("io load length");
   a_mem_store_len: assert property ($rose(mem_wr) && !io |-> mem_wr [*2] ##1 !mem_wr)
      else $error("memory store length");
   a_store_follows: assert property ($fell(mem_rd) |-> ##[0:2] $rose(mem_wr))
      else $error("load not followed by store");
   a_first_load: assert property ($rose(bus_grant) |-> ##[1:8] mem_rd)
      else $error("first load late");
   a_irq_pulse: assert property (transfer_done_irq |=> !transfer_done_irq)
      else $error("irq longer than one cycle");
   a_req_release: assert property (transfer_done_irq |-> ##[0:3] !bus_request)
      else $error("bus kept after done");
   cover property ($rose(transfer_done_irq));
   cover property ($rose(mem_rd) && io);
   cover property ($fell(bus_request) && !transfer_done_irq);
endmodule // atd_chk
bind atd_top atd_chk u_chk (.aclk, .aresetn, .bus_request, .bus_grant, .mem_rd, .mem_wr,
   .mem_addr, .transfer_done_irq);
`default_nettype wire

//--- test/atd_core_model.sv
// model: processor core side, bus arbitration and memory read data
`timescale 1ns/1ps
`default_nettype none
module atd_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] gdly,
   input wire logic bus_request,
   output logic bus_grant,
   input wire logic mem_rd,
   input wire logic [17:0] mem_addr,
   output logic [7:0] mem_rdata
);
   // ****************************************
   // arbitration and memory
   // ****************************************
   logic [2:0] wait_q;
   logic [7:0] junk_q;
   always_ff @(posedge aclk) begin
      junk_q <= aresetn ? junk_q + 8'h3B : 8'h00;
      if (!aresetn || !bus_request) begin
         wait_q <= 3'h0;
         bus_grant <= 1'b0;
      end else if (wait_q >= gdly) begin
         bus_grant <= 1'b1;
      end else begin
         wait_q <= wait_q + 3'h1;
      end
   end
   // an idle bus shows a moving pattern so a stale byte cannot pass for data
   assign mem_rdata = mem_rd ? mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5 : junk_q;
endmodule // atd_core_model
`default_nettype wire

//--- test/tb.sv
// testbench: registers, standard and burst transfers of the auto transfer unit
`timescale 1ns/1ps
`default_nettype none
module tb
   import atd_pkg::*;
;
   logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, ext0_request_flag, bus_request, bus_grant;
   logic mem_rd, mem_wr, transfer_done_irq, prd, pwr;
   logic [7:0] s_awaddr, s_araddr, mem_wdata, mem_rdata, c1;
   logic [31:0] s_wdata, s_rdata, seed, g;
   logic [3:0] s_wstrb, sel;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic [15:0] trigger_in;
   logic [17:0] mem_addr, p0, p1;
   logic [2:0] gdly;
   logic [17:0] lq[$], sq[$];
   logic [7:0] dq[$];
   int err_total, tests_run, irqs, k, n;
   atd_top dut (.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready,
      .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr,
      .s_rvalid, .s_rready, .s_rdata, .s_rresp, .trigger_in, .ext0_request_flag, .bus_request,
      .bus_grant, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .transfer_done_irq);
   atd_core_model core (.aclk, .aresetn, .gdly, .bus_request, .bus_grant, .mem_rd, .mem_addr,
      .mem_rdata);
   // ****************************************
   // helpers
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (mem_rd && !prd) lq.push_back(mem_addr);
      if (mem_wr && !pwr) sq.push_back(mem_addr);
      if (mem_wr && !pwr) dq.push_back(mem_wdata);
      if (transfer_done_irq === 1'b1) irqs++;
      prd <= mem_rd;
      pwr <= mem_wr;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] md(input logic [17:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   task automatic end_sim();
      if (err_total == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int i, input int lim);
      if (i >= lim) begin
         err_total++;
         $display("mismatch %0t timeout", $time);
         end_sim();
      end
   endtask
   // bus tasks end one edge late so no signal is driven twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      int i;
      s_awvalid <= 1'b1;
      s_awaddr <= a;
      s_wvalid <= 1'b1;
      s_wdata <= d;
      s_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) break;
      end
      rsp = s_bresp;
      s_bready <= 1'b0;
      tmo(i, 50);
      chk(32'(rsp), 32'(er));
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      s_arvalid <= 1'b1;
      s_araddr <= a;
      s_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) break;
      end
      g = s_rdata;
      rsp = s_rresp;
      s_rready <= 1'b0;
      tmo(i, 50);
      @(posedge aclk);
   endtask
   task automatic setp(input logic [17:0] a0, input logic [17:0] a1);
      logic [7:0] a[6];
      logic [7:0] v[6];
      a = '{ATD_OFF_P0L, ATD_OFF_P0M, ATD_OFF_P0H, ATD_OFF_P1L, ATD_OFF_P1M, ATD_OFF_P1H};
      v = '{a0[7:0], a0[15:8], 8'(a0[17:16]), a1[7:0], a1[15:8], 8'(a1[17:16])};
      for (int i = 0; i < 6; i++) wr(a[i], 32'(v[i]));
      for (int i = 0; i < 6; i++) begin
         rd(a[i]);
         chk(32'(g[7:0]), 32'(v[i]));
      end
   endtask
   task automatic idle();
      int i;
      for (i = 0; i < 600; i++) begin
         @(posedge aclk);
         if (i > 8 && !bus_request) break;
      end
      tmo(i, 600);
      repeat (3) @(posedge aclk);
   endtask
   task automatic go(input logic [7:0] c);
      gdly <= 3'(rnd() % 4);
      wr(ATD_OFF_CTRL1, 32'(c) | (32'h1 << ATD_C1_SWACT_BIT));
      idle();
   endtask
   task automatic pulse(input logic [3:0] s);
      trigger_in <= 16'h1 << s;
      repeat (2) @(posedge aclk);
      trigger_in <= 16'h0;
      idle();
   endtask
   task automatic cmpq(input int m, input logic [17:0] s, input logic [17:0] d, input int si,
         input int di);
      chk(32'(lq.size()), 32'(m));
      for (int i = 0; i < m; i++) begin
         chk(32'(lq[i]), 32'(s + 18'(si * i)));
         chk(32'(sq[i]), 32'(d + 18'(di * i)));
         chk(32'(dq[i]), 32'(md(s + 18'(si * i))));
      end
      lq.delete();
      sq.delete();
      dq.delete();
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, ext0_request_flag} = 6'h00;
      {aresetn, s_awaddr, s_araddr, s_wdata, trigger_in, gdly} = '0;
      s_wstrb = 4'hF;
      seed = 32'h0001_6D8F;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h28);
      chk(32'(rsp), 32'(ATD_RESP_SLVERR));
      wr(8'h28, 32'h0, ATD_RESP_SLVERR);
      p0 = 18'(rnd());
      p1 = 18'(rnd()) & 18'h3_FFFE;
      setp(p0, p1);
      go(8'h00);
      chk(32'(lq.size()), 32'h0);
      for (int m = 0; m < 16; m++) begin
         wr(ATD_OFF_CTRL0, 32'(m));
         wr(ATD_OFF_COUNT, 32'h1);
         k = irqs;
         go(8'h00);
         chk(32'(irqs - k), 32'h1);
         chk(32'(lq.size() > 0 && lq.size() == sq.size()), 32'h1);
         rd(ATD_OFF_COUNT);
         chk(32'(g[7:0]), 32'h0);
         rd(ATD_OFF_STAT);
         chk(32'(g[7:0]), 32'h04);
         lq.delete();
         sq.delete();
         dq.delete();
         go(8'h00);
         chk(32'(lq.size()), 32'h0);
      end
      p0 = 18'(rnd());
      setp(p0, p1);
      sel = 4'(rnd());
      wr(ATD_OFF_CTRL0, 32'h0);
      wr(ATD_OFF_CTRL1, 32'(sel));
      wr(ATD_OFF_COUNT, 32'h2);
      k = irqs;
      pulse(sel + 4'h1);
      chk(32'(lq.size()), 32'h0);
      repeat (3) pulse(sel);
      cmpq(2, p0, {ATD_IO_UPPER, p1[7:0]}, 0, 0);
      chk(32'(irqs - k), 32'h1);
      for (int f = 0; f < 2; f++) begin
         wr(ATD_OFF_CTRL0, 32'h2 | 32'(f << ATD_C0_INCDIS_BIT));
         wr(ATD_OFF_COUNT, 32'h2);
         go(8'h00);
         go(8'h00);
         cmpq(2, p0, {ATD_IO_UPPER, p1[7:0]}, 1 - f, 0);
         p0 = p0 + 18'(2 - 2 * f);
      end
      wr(ATD_OFF_CTRL0, 32'h4);
      wr(ATD_OFF_COUNT, 32'h1);
      go(8'h00);
      cmpq(2, p0, {ATD_IO_UPPER, p1[7:0]}, 1, 1);
      for (int m = 14; m < 16; m++) begin
         p0 = 18'(rnd());
         p1 = 18'(rnd());
         setp(p0, p1);
         n = 3 + int'(rnd() % 6);
         wr(ATD_OFF_CTRL0, 32'(m));
         wr(ATD_OFF_COUNT, 32'(n));
         ext0_request_flag <= 1'b1;
         k = irqs;
         go(8'h00);
         cmpq(n, m == 14 ? p0 : p1, m == 14 ? p1 : p0, 1, 1);
         chk(32'(irqs - k), 32'h1);
         p0 = p0 + 18'(n);
         p1 = p1 + 18'(n);
         ext0_request_flag <= 1'b0;
      end
      wr(ATD_OFF_CTRL0, 32'(ATD_MODE_BURST_E));
      wr(ATD_OFF_COUNT, 32'h6);
      c1 = 8'h1 << ATD_C1_BSTOP_BIT;
      wr(ATD_OFF_CTRL1, 32'(c1) | (32'h1 << ATD_C1_SWACT_BIT));
      for (n = 0; n < 200 && sq.size() < 2; n++) @(posedge aclk);
      tmo(n, 200);
      ext0_request_flag <= 1'b1;
      idle();
      ext0_request_flag <= 1'b0;
      k = sq.size();
      chk(32'(k <= 4), 32'h1);
      rd(ATD_OFF_COUNT);
      chk(32'(g[7:0]), 32'(6 - k));
      go(c1);
      cmpq(6, p0, p1, 1, 1);
      end_sim();
   end
endmodule // tb
`default_nettype wire
